//--- core/d3hd_regs.svh
// Register offsets, field positions, codes and counts of the link controller
`ifndef D3HD_REGS_SVH
`define D3HD_REGS_SVH
`define D3HD_REG_IRQ    6'h2c
`define D3HD_REG_TXF    6'h37
`define D3HD_REG_RXF    6'h38
`define D3HD_REG_MLEN   6'h39
`define D3HD_REG_DEPTH  6'h3a
`define D3HD_REG_FCSC   6'h3b
`define D3HD_REG_ABTC   6'h3c
`define D3HD_REG_CTL    6'h3d
`define D3HD_CTL_RESET  8'h00
`define D3HD_CTL_MASK   8'h17
`define D3HD_BIT_TXEN   0
`define D3HD_BIT_HALF   1
`define D3HD_BIT_EOM    2
`define D3HD_BIT_RXEN   4
`define D3HD_RS_GOOD    3'h2
`define D3HD_RS_FCS     3'h3
`define D3HD_RS_ABORT   3'h4
`define D3HD_RS_INV     3'h7
`define D3HD_TX_UNDER   2'h3
`define D3HD_FLAG       8'h7e
`define D3HD_ABORT_CHAR 8'hff
`define D3HD_CRC_INIT   16'hffff
`define D3HD_CRC_POLY   16'h8408
`define D3HD_SHORT_MAX  8'h04
`define D3HD_STUFF_RUN  3'h5
`define D3HD_TX_DEPTH   80
`define D3HD_RX_DEPTH   159
`endif

//--- core/d3hd_pkg.sv
// Types shared by the link controller
package d3hd_pkg;
   typedef enum logic [1:0] {S_FLAG = 2'b00, S_DATA = 2'b01, S_FCS = 2'b11, S_ABORT = 2'b10} d3hd_tx_state_t;
   typedef enum logic [1:0] {E_GOOD = 2'b00, E_FCS = 2'b01, E_ABORT = 2'b10, E_PART = 2'b11} d3hd_end_t;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } d3hd_bus_t;
   typedef struct packed {
      logic      byteValid;
      logic [7:0] data;
      logic      endValid;
      d3hd_end_t kind;
   } d3hd_rx_t;
endpackage

//--- core/d3hd_link.sv
// Path maintenance link controller: FIFOs, register file, receive status, transmit framer
`timescale 1ns/1ns
`include "d3hd_regs.svh"

// ==========================================
// Byte FIFO
module d3hd_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16,
   parameter int CW    = $clog2(DEPTH + 1)
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          inValid,
   output logic               inReady,
   input  wire logic [W-1:0]  inData,
   output logic               outValid,
   input  wire logic          outReady,
   output logic [W-1:0]       outData,
   output logic [CW-1:0]      level
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wp_reg;
   logic [PW-1:0] rp_reg;
   logic          push;
   logic          pop;

   // Honest full and empty straight from the level
   assign inReady  = level != CW'(DEPTH);
   assign outValid = level != '0;
   assign outData  = mem[rp_reg];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // Storage has no reset; only pointers matter
   always_ff @(posedge clk)
      if (push)
         mem[wp_reg] <= inData;

   // Pointers and level
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         wp_reg <= '0;
         rp_reg <= '0;
         level  <= '0;
      end
      else
      begin
         if (push)
            wp_reg <= (wp_reg == PW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
         if (pop)
            rp_reg <= (rp_reg == PW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
         level <= level + CW'(push) - CW'(pop);
      end
endmodule

// ==========================================
// Controller top
module d3hd_link #(
   parameter int TX_DEPTH = `D3HD_TX_DEPTH,
   parameter int RX_DEPTH = `D3HD_RX_DEPTH
) (
   input  wire logic               clk,
   input  wire logic               rstn,
   input  wire d3hd_pkg::d3hd_bus_t bus,
   output logic [7:0]              rdData,
   input  wire d3hd_pkg::d3hd_rx_t  rxIn,
   output logic                    rxReady,
   output logic                    txFifoReady,
   input  wire logic               compatSel,
   input  wire logic               framingSourceMode,
   input  wire logic               bitReq,
   input  wire logic               extCBit,
   input  wire logic               stuffCBit,
   output logic                    dlBit
);
   localparam int TCW = $clog2(TX_DEPTH + 1);
   localparam int RCW = $clog2(RX_DEPTH + 1);

   logic                    rst_n;
   logic                    rstS1_reg;
   logic [7:0]              ctl_reg;
   logic [2:0]              rxStat_reg;
   logic [1:0]              txFs_reg;
   logic                    txSvc_reg;
   logic [7:0]              mlen_reg;
   logic [7:0]              frameCnt_reg;
   logic [7:0]              fcsCnt_reg;
   logic [7:0]              abtCnt_reg;
   d3hd_pkg::d3hd_tx_state_t st_reg;
   logic [7:0]              shift_reg;
   logic [2:0]              bitCnt_reg;
   logic [2:0]              ones_reg;
   logic [15:0]             crc_reg;
   logic                    fcsHi_reg;
   logic [TCW-1:0]          txLevPrev_reg;
   logic                    rxOn;
   logic                    txOn;
   logic                    rdIrq;
   logic                    rdFcs;
   logic                    rdAbt;
   logic                    rdFifo;
   logic                    shortFrame;
   logic                    rxEnd;
   logic                    rxOut;
   logic [7:0]              rxData;
   logic [RCW-1:0]          rxLevel;
   logic                    txValid;
   logic [7:0]              txData;
   logic [TCW-1:0]          txLevel;
   logic                    stuffing;
   logic                    curBit;
   logic                    boundary;
   logic                    underflow;
   logic                    fcsDone;
   logic                    halfEvt;
   logic                    pop;
   logic [15:0]             crcNext;

   // ==========================================
   // Reset release through two flops
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         rstS1_reg <= 1'b0;
         rst_n     <= 1'b0;
      end
      else
      begin
         rstS1_reg <= 1'b1;
         rst_n     <= rstS1_reg;
      end

   // ==========================================
   // Register decode
   assign rxOn   = ctl_reg[`D3HD_BIT_RXEN];
   assign txOn   = ctl_reg[`D3HD_BIT_TXEN] && !compatSel;
   assign rdIrq  = bus.rd && bus.addr == `D3HD_REG_IRQ;
   assign rdFcs  = bus.rd && bus.addr == `D3HD_REG_FCSC;
   assign rdAbt  = bus.rd && bus.addr == `D3HD_REG_ABTC;
   assign rdFifo = bus.rd && bus.addr == `D3HD_REG_RXF;

   // Read data is registered; unmapped offsets read zero
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         rdData <= 8'h00;
      else if (bus.rd)
         unique case (bus.addr)
            `D3HD_REG_IRQ:   rdData <= {rxStat_reg, 2'b00, txFs_reg, txSvc_reg};
            `D3HD_REG_RXF:   rdData <= rxOut ? rxData : 8'h00;
            `D3HD_REG_MLEN:  rdData <= mlen_reg;
            `D3HD_REG_DEPTH: rdData <= 8'(rxLevel);
            `D3HD_REG_FCSC:  rdData <= fcsCnt_reg;
            `D3HD_REG_ABTC:  rdData <= abtCnt_reg;
            `D3HD_REG_CTL:   rdData <= ctl_reg;
            default:         rdData <= 8'h00;
         endcase

   // Control; the end-of-message bit is cleared when consumed, a host write wins
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         ctl_reg <= `D3HD_CTL_RESET;
      else
      begin
         if (st_reg == d3hd_pkg::S_DATA && boundary && !txValid && bitReq && txOn && !stuffing)
            ctl_reg[`D3HD_BIT_EOM] <= 1'b0;
         if (bus.wr && bus.addr == `D3HD_REG_CTL)
            ctl_reg <= bus.wdata & `D3HD_CTL_MASK;
      end

   // ==========================================
   // Receive side: frames of any length and content are stored as received
   assign rxEnd      = rxOn && rxIn.endValid;
   assign shortFrame = frameCnt_reg <= `D3HD_SHORT_MAX;

   d3hd_fifo #(.W(8), .DEPTH(RX_DEPTH)) rxFifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (rxOn && rxIn.byteValid),
      .inReady  (rxReady),
      .inData   (rxIn.data),
      .outValid (rxOut),
      .outReady (rdFifo),
      .outData  (rxData),
      .level    (rxLevel)
   );

   // Frame length and message length; depth is never touched at message end
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         frameCnt_reg <= 8'h00;
         mlen_reg     <= 8'h00;
      end
      else if (rxEnd)
      begin
         mlen_reg     <= frameCnt_reg;
         frameCnt_reg <= 8'h00;
      end
      else if (rxOn && rxIn.byteValid && rxReady)
         frameCnt_reg <= frameCnt_reg + 8'h01;

   // Message status: a new end beats a clearing read
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         rxStat_reg <= 3'h0;
      else if (rxEnd)
         unique case (rxIn.kind)
            d3hd_pkg::E_ABORT: rxStat_reg <= `D3HD_RS_ABORT;
            d3hd_pkg::E_PART:  rxStat_reg <= `D3HD_RS_INV;
            d3hd_pkg::E_FCS:   rxStat_reg <= shortFrame ? `D3HD_RS_INV : `D3HD_RS_FCS;
            d3hd_pkg::E_GOOD:  rxStat_reg <= shortFrame ? `D3HD_RS_INV : `D3HD_RS_GOOD;
         endcase
      else if (rdIrq)
         rxStat_reg <= 3'h0;

   // Error counters clear on read; a count in the read cycle survives as one
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         fcsCnt_reg <= 8'h00;
      else if (rxEnd && rxIn.kind == d3hd_pkg::E_FCS && !shortFrame)
         fcsCnt_reg <= rdFcs ? 8'h01 : fcsCnt_reg + 8'h01;
      else if (rdFcs)
         fcsCnt_reg <= 8'h00;

   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         abtCnt_reg <= 8'h00;
      else if (rxEnd && rxIn.kind == d3hd_pkg::E_ABORT)
         abtCnt_reg <= rdAbt ? 8'h01 : abtCnt_reg + 8'h01;
      else if (rdAbt)
         abtCnt_reg <= 8'h00;

   // ==========================================
   // Transmit FIFO, loaded by host writes; back-pressure shows on txFifoReady
   d3hd_fifo #(.W(8), .DEPTH(TX_DEPTH)) txFifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (bus.wr && bus.addr == `D3HD_REG_TXF),
      .inReady  (txFifoReady),
      .inData   (bus.wdata),
      .outValid (txValid),
      .outReady (pop),
      .outData  (txData),
      .level    (txLevel)
   );

   // Bit serialiser decode; the run counter only grows in message and checksum bytes,
   // so a run that ends the checksum still gets its zero before the closing flag
   assign stuffing  = ones_reg == `D3HD_STUFF_RUN;
   assign curBit    = shift_reg[0];
   assign boundary  = bitCnt_reg == 3'h7;
   assign crcNext   = (crc_reg >> 1) ^ ((crc_reg[0] ^ curBit) ? `D3HD_CRC_POLY : 16'h0000);
   assign pop       = bitReq && txOn && !stuffing && boundary && txValid
                      && (st_reg == d3hd_pkg::S_FLAG || st_reg == d3hd_pkg::S_DATA);
   assign underflow = bitReq && txOn && !stuffing && boundary && !txValid
                      && st_reg == d3hd_pkg::S_DATA && !ctl_reg[`D3HD_BIT_EOM];
   assign fcsDone   = bitReq && txOn && !stuffing && boundary && st_reg == d3hd_pkg::S_FCS && fcsHi_reg;

   // Framer: flags while idle, data with checksum, abort on underflow
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         st_reg     <= d3hd_pkg::S_FLAG;
         shift_reg  <= `D3HD_FLAG;
         bitCnt_reg <= 3'h0;
         ones_reg   <= 3'h0;
         crc_reg    <= `D3HD_CRC_INIT;
         fcsHi_reg  <= 1'b0;
      end
      else if (!txOn)
      begin
         st_reg     <= d3hd_pkg::S_FLAG;
         shift_reg  <= `D3HD_FLAG;
         bitCnt_reg <= 3'h0;
         ones_reg   <= 3'h0;
         crc_reg    <= `D3HD_CRC_INIT;
      end
      else if (bitReq && stuffing)
         ones_reg <= 3'h0;
      else if (bitReq)
      begin
         bitCnt_reg <= bitCnt_reg + 3'h1;
         ones_reg   <= (curBit && st_reg != d3hd_pkg::S_FLAG && st_reg != d3hd_pkg::S_ABORT)
                       ? ones_reg + 3'h1 : 3'h0;
         shift_reg  <= shift_reg >> 1;
         crc_reg    <= (st_reg == d3hd_pkg::S_DATA) ? crcNext
                     : (st_reg == d3hd_pkg::S_FCS) ? crc_reg : `D3HD_CRC_INIT;
         if (boundary)
            unique case (st_reg)
               d3hd_pkg::S_FLAG, d3hd_pkg::S_DATA:
                  if (txValid)
                  begin
                     shift_reg <= txData;
                     st_reg    <= d3hd_pkg::S_DATA;
                  end
                  else if (st_reg == d3hd_pkg::S_FLAG)
                     shift_reg <= `D3HD_FLAG;
                  else if (ctl_reg[`D3HD_BIT_EOM])
                  begin
                     shift_reg <= ~crcNext[7:0];
                     st_reg    <= d3hd_pkg::S_FCS;
                     fcsHi_reg <= 1'b0;
                  end
                  else
                  begin
                     shift_reg <= `D3HD_ABORT_CHAR;
                     st_reg    <= d3hd_pkg::S_ABORT;
                  end
               d3hd_pkg::S_FCS:
                  if (!fcsHi_reg)
                  begin
                     shift_reg <= ~crc_reg[15:8];
                     fcsHi_reg <= 1'b1;
                  end
                  else
                  begin
                     shift_reg <= `D3HD_FLAG;
                     st_reg    <= d3hd_pkg::S_FLAG;
                  end
               d3hd_pkg::S_ABORT:
               begin
                  shift_reg <= `D3HD_FLAG;
                  st_reg    <= d3hd_pkg::S_FLAG;
               end
            endcase
      end

   // Line bit: framer when enabled, else external or stuffing source
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         dlBit <= 1'b0;
      else if (bitReq)
         dlBit <= txOn ? (curBit && !stuffing) : (framingSourceMode ? stuffCBit : extCBit);

   // Service request and underflow status; events win over a clearing read
   assign halfEvt = ctl_reg[`D3HD_BIT_HALF] && txLevPrev_reg > TCW'(TX_DEPTH / 2)
                    && txLevel <= TCW'(TX_DEPTH / 2);
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         txLevPrev_reg <= '0;
         txSvc_reg     <= 1'b0;
         txFs_reg      <= 2'h0;
      end
      else
      begin
         txLevPrev_reg <= txLevel;
         if (fcsDone || halfEvt)
            txSvc_reg <= 1'b1;
         else if (rdIrq)
            txSvc_reg <= 1'b0;
         if (underflow)
            txFs_reg <= `D3HD_TX_UNDER;
         else if (rdIrq)
            txFs_reg <= 2'h0;
      end

   // ==========================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence lastFcsBit;
      fcsDone;
   endsequence
   sequence flagFollows;
      st_reg == d3hd_pkg::S_FLAG && shift_reg == `D3HD_FLAG;
   endsequence

   fcs_then_flag_a: assert property (lastFcsBit |=> flagFollows ##0 txSvc_reg)
      else $error("no flag or service request after checksum");
   disabled_source_a: assert property (bitReq && !txOn |=>
      dlBit == ($past(framingSourceMode) ? $past(stuffCBit) : $past(extCBit)))
      else $error("disabled line bit from wrong source");
   disabled_idle_a: assert property (!txOn |=> st_reg == d3hd_pkg::S_FLAG)
      else $error("framer left idle while disabled");
   underflow_abort_a: assert property (underflow |=> txFs_reg == `D3HD_TX_UNDER
      && st_reg == d3hd_pkg::S_ABORT && shift_reg == `D3HD_ABORT_CHAR)
      else $error("underflow not flagged with abort");
   short_status_a: assert property (rxEnd && shortFrame && rxIn.kind != d3hd_pkg::E_ABORT
      |=> rxStat_reg == `D3HD_RS_INV && $stable(fcsCnt_reg))
      else $error("short frame status wrong");
   fcs_count_a: assert property (rxEnd && rxIn.kind == d3hd_pkg::E_FCS && !shortFrame && !rdFcs
      |=> rxStat_reg == `D3HD_RS_FCS && fcsCnt_reg == $past(fcsCnt_reg) + 8'h01)
      else $error("checksum error not counted");
   abort_status_a: assert property (rxEnd && rxIn.kind == d3hd_pkg::E_ABORT && !rdAbt
      |=> rxStat_reg == `D3HD_RS_ABORT && abtCnt_reg == $past(abtCnt_reg) + 8'h01)
      else $error("abort not recorded");
   depth_hold_a: assert property (rxEnd && !rxIn.byteValid && !rdFifo |=> $stable(rxLevel)
      && mlen_reg == $past(frameCnt_reg))
      else $error("depth changed at message end");
   rx_off_a: assert property (!rxOn && !rdIrq |=> $stable(rxStat_reg) && $stable(rxLevel)
      || $past(rdFifo))
      else $error("disabled receiver changed state");
endmodule

//--- verification/d3hd_cbit_model.sv
// Far-side model of the data-link C-bit slots of the DS3 frame
`timescale 1ns/1ns

// ==========================================
// C-bit channel model
module d3hd_cbit_model (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic slow,
   output logic      bitReq,
   output logic      extCBit,
   output logic      stuffCBit
);
   logic [2:0] slotCnt;

   // Slot pulses every 2 or 5 cycles; source bits are redrawn from $urandom each slot, so a stale copy can still match by luck
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         slotCnt <= 3'h0;
         bitReq <= 1'b0;
         extCBit <= 1'b0;
         stuffCBit <= 1'b1;
      end
      else
      begin
         bitReq <= (slotCnt == 3'h0);
         slotCnt <= (slotCnt == 3'h0) ? (slow ? 3'h4 : 3'h1) : slotCnt - 3'h1;
         if (slotCnt == 3'h1)
         begin
            extCBit <= $urandom;
            stuffCBit <= $urandom;
         end
      end
   end
endmodule

//--- verification/d3hd_link_tb_top.sv
// Self-checking bench of the link controller: registers, receive status, transmit framing
`timescale 1ns/1ns

// ==========================================
// Bench top
module d3hd_link_tb_top;
   logic                clk;
   logic                rstn;
   d3hd_pkg::d3hd_bus_t bus;
   logic [7:0]          rdData;
   d3hd_pkg::d3hd_rx_t  rxIn;
   logic                rxReady, txFifoReady, compatSel, framingSourceMode;
   logic                bitReq, extCBit, stuffCBit, dlBit, slow;
   logic                rdPend, bitPend, chkPass, capture;
   int                  mismatches, checked, tot;
   logic [7:0]          expQ[$], mskQ[$], rxQ[$];
   logic                bitQ[$], expBitQ[$];

   d3hd_link i_d3hd_link (.clk(clk), .rstn(rstn), .bus(bus), .rdData(rdData), .rxIn(rxIn), .rxReady(rxReady),
      .txFifoReady(txFifoReady), .compatSel(compatSel), .framingSourceMode(framingSourceMode), .bitReq(bitReq),
      .extCBit(extCBit), .stuffCBit(stuffCBit), .dlBit(dlBit));
   d3hd_cbit_model i_d3hd_cbit_model (.clk(clk), .rstn(rstn), .slow(slow), .bitReq(bitReq), .extCBit(extCBit),
      .stuffCBit(stuffCBit));

   // Clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ==========================================
   // Comparison, verdict and bus tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   // Expected value is noted here and compared when the read data appears
   task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk);
      bus.rd <= 1'b1;
      bus.addr <= a;
      expQ.push_back(e);
      mskQ.push_back(m);
      @(posedge clk);
      bus.rd <= 1'b0;
   endtask

   // One destuffed octet every two cycles, then the end marker two cycles after the last byte
   task automatic rxFrame(input int n, input logic [1:0] k, input bit keep);
      logic [7:0] b;
      for (int i = 0; i < n; i++)
      begin
         b = $urandom;
         if (keep) rxQ.push_back(b);
         @(posedge clk);
         rxIn.byteValid <= 1'b1;
         rxIn.data <= b;
         @(posedge clk);
         rxIn.byteValid <= 1'b0;
      end
      @(posedge clk);
      rxIn.endValid <= 1'b1;
      rxIn.kind <= d3hd_pkg::d3hd_end_t'(k);
      @(posedge clk);
      rxIn.endValid <= 1'b0;
   endtask

   function automatic logic [7:0] head8();
      for (int i = 0; i < 8; i++) head8[i] = bitQ[i];
   endfunction

   // Loads n bytes while idle, then enables; expected line bits are built here with our own checksum
   task automatic txFrame(input int n, input logic [7:0] ctl);
      logic raw[$];
      logic exp[$];
      logic [15:0] crc;
      logic [7:0] d;
      int run;
      crc = 16'hffff;
      for (int i = 0; i < n; i++)
      begin
         d = $urandom;
         wr(6'h37, d);
         for (int j = 0; j < 8; j++)
         begin
            raw.push_back(d[j]);
            crc = (crc[0] ^ d[j]) ? ((crc >> 1) ^ 16'h8408) : (crc >> 1);
         end
      end
      if (n == 80)
      begin
         @(negedge clk);
         check({7'h00, txFifoReady}, 8'h00);
         wr(6'h37, 8'h5a);
      end
      if (ctl[2])
         for (int j = 0; j < 16; j++) raw.push_back(~crc[j]);
      run = 0;
      foreach (raw[i])
      begin
         exp.push_back(raw[i]);
         run = raw[i] ? run + 1 : 0;
         if (run == 5)
         begin
            exp.push_back(1'b0);
            run = 0;
         end
      end
      for (int j = 0; j < 8; j++) exp.push_back(ctl[2] ? j != 0 && j != 7 : 1'b1);
      wr(6'h3d, ctl);
      // Skip the slot taken at the enabling edge, which still carries the disabled source
      @(posedge clk);
      @(negedge clk);
      bitQ.delete();
      capture = 1'b1;
      for (int k = 0; k < 20000 && bitQ.size() < exp.size() + 48; k++) @(posedge clk);
      if (bitQ.size() < exp.size() + 48)
      begin
         mismatches++;
         results();
      end
      check(head8(), 8'h7e);
      repeat (8) void'(bitQ.pop_front());
      foreach (exp[i]) check({7'h00, bitQ[i]}, {7'h00, exp[i]});
      capture = 1'b0;
      wr(6'h3d, 8'h00);
   endtask

   // ==========================================
   // Output watcher: read data, captured line bits, disabled-path bits
   always @(posedge clk)
   begin
      if (rdPend)
      begin
         check(rdData & mskQ[0], expQ[0] & mskQ[0]);
         void'(expQ.pop_front());
         void'(mskQ.pop_front());
      end
      if (bitPend && capture) bitQ.push_back(dlBit);
      if (bitPend && chkPass && expBitQ.size() > 0) check({7'h00, dlBit}, {7'h00, expBitQ.pop_front()});
      if (bitReq && chkPass) expBitQ.push_back(framingSourceMode ? stuffCBit : extCBit);
      rdPend <= bus.rd;
      bitPend <= bitReq;
   end

   // ==========================================
   // Main sequence
   initial
   begin
      int n[5] = '{3, 6, 5, 5, 6};
      int st[5] = '{7, 3, 4, 7, 2};
      mismatches = 0;
      checked = 0;
      tot = 0;
      rstn = 1'b0;
      bus = '0;
      rxIn = '0;
      compatSel = 1'b0;
      framingSourceMode = 1'b0;
      slow = 1'b0;
      rdPend = 1'b0;
      bitPend = 1'b0;
      chkPass = 1'b0;
      capture = 1'b0;
      void'($urandom(32'h6623a2f5));
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      // Reset values, unmapped offset, reserved control bits
      rd(6'h3d, 8'h00, 8'hff);
      rd(6'h30, 8'h00, 8'hff);
      wr(6'h3d, 8'hee);
      rd(6'h3d, 8'h06, 8'hff);
      wr(6'h3d, 8'h00);
      // Disabled transmitter: by control bit and by the compatibility pin, both bit sources
      for (int m = 0; m < 4; m++)
      begin
         framingSourceMode <= m[0];
         compatSel <= m[1];
         slow <= m[1];
         wr(6'h3d, {7'h00, m[1]});
         @(negedge clk);
         expBitQ.delete();
         chkPass = 1'b1;
         repeat (60) @(posedge clk);
         @(negedge clk);
         chkPass = 0;
      end
      // Transmitter off before the pin is released, so framing starts from idle
      wr(6'h3d, 8'h00);
      @(posedge clk);
      compatSel <= 1'b0;
      slow <= 1'b0;
      // Ended frame, then full FIFO with half-level service and underflow abort
      txFrame(2, 8'h05);
      rd(6'h2c, 8'h01, 8'h07);
      txFrame(80, 8'h03);
      rd(6'h2c, 8'h07, 8'h07);
      // Receive end kinds; depth keeps accumulating over messages
      wr(6'h3d, 8'h10);
      for (int i = 0; i < 5; i++)
      begin
         tot += n[i];
         rxFrame(n[i], i == 4 ? 2'h0 : i[1:0], 1'b1);
         rd(6'h2c, st[i] << 5, 8'he0);
         rd(6'h39, n[i], 8'hff);
         rd(6'h3a, tot, 8'hff);
      end
      rd(6'h3b, 8'h01, 8'hff);
      rd(6'h3b, 8'h00, 8'hff);
      rd(6'h3c, 8'h01, 8'hff);
      // Host drains everything, bad and aborted messages too, until the count is zero
      for (int i = 0; i < tot; i++) rd(6'h38, rxQ.pop_front(), 8'hff);
      rd(6'h3a, 8'h00, 8'hff);
      @(negedge clk);
      check({7'h00, rxReady}, 8'h01);
      wr(6'h3d, 8'h00);
      rxFrame(4, 2'h0, 1'b0);
      rd(6'h3a, 8'h00, 8'hff);
      rd(6'h2c, 8'h00, 8'he0);
      repeat (3) @(posedge clk);
      results();
   end
endmodule
